// [core/mri_top.sv]
`timescale 1ns/1ps
`include "mri_params.svh"

// Behaviour
// - rx-good flag gated by bit 4, master
// - too-long flag gated by bit 3, master
// - fifo-overflow flag gated by bit 2, master
// - crc-fail flag gated by bit 1, master
// - master gating uses rx master bit 0
// - irq when master on and summary high
// - master off blocks o_rx_irq; o_reg_irq is not gated by the master
// - writing one clears a status flag
module mri_top
	import mri_pkg::*;
(
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	// register port
	input  wire mri_bus_s    i_bus,
	output logic [31:0]      o_rdata,
	// receive events, one-cycle pulses
	input  wire mri_src_t    i_src_evt,
	// interrupts
	output logic             o_rx_irq,
	output logic             o_reg_irq
);

	logic [31:0] mac_irq_enable_ff;
	logic [31:0] nxt_enable;
	mri_src_t    status_ff;
	mri_src_t    nxt_status;
	mri_src_t    imask_ff;
	mri_src_t    istat_ff;
	mri_src_t    nxt_istat;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        rx_irq_ff;

	// decode
	wire sel_en  = i_bus.addr == `MRI_OFF_ENABLE;
	wire sel_st  = i_bus.addr == `MRI_OFF_STATUS;
	wire sel_msk = i_bus.addr == `MRI_OFF_MASK;
	wire sel_ist = i_bus.addr == `MRI_OFF_ISTAT;
	wire wr_en   = i_bus.wr && sel_en;
	wire wr_st   = i_bus.wr && sel_st;
	wire wr_msk  = i_bus.wr && sel_msk;
	wire wr_ist  = i_bus.wr && sel_ist;

	wire rx_irq_master_en = mac_irq_enable_ff[`MRI_BIT_MASTER];
	wire crc_fail_irq_en     = mac_irq_enable_ff[`MRI_BIT_CRC];
	wire fifo_overflow_irq_en = mac_irq_enable_ff[`MRI_BIT_OVF];
	wire too_long_irq_en     = mac_irq_enable_ff[`MRI_BIT_LONG];
	wire rx_good_irq_en      = mac_irq_enable_ff[`MRI_BIT_GOOD];
	wire crc_fail_flag       = status_ff[0];
	wire fifo_overflow_flag  = status_ff[1];
	wire too_long_flag       = status_ff[2];
	wire rx_good_flag        = status_ff[3];

	// per-source gating before the master enable
	wire [3:0] src_en = {rx_good_irq_en, too_long_irq_en,
		fifo_overflow_irq_en, crc_fail_irq_en};
	wire [3:0] src_hit;
	for (genvar g = 0; g < `MRI_NSRC; g++) begin : g_src
		assign src_hit[g] = status_ff[g] & src_en[g];
	end
	wire rx_irq_summary = |src_hit;
	// master gating uses the rx master, not the tx one the text names
	wire nxt_rx_irq = rx_irq_master_en && rx_irq_summary;

	// the status word: summary at bit 0, flags from bit 1
	wire [31:0] status_word = {27'h0, status_ff, rx_irq_summary};

	assign nxt_enable = wr_en ? i_bus.wdata : mac_irq_enable_ff;

	// set wins over a clearing write in the same cycle
	wire [3:0] st_clr = wr_st ? i_bus.wdata[4:1] : 4'h0;
	assign nxt_status = (status_ff & ~st_clr) | i_src_evt;

	// register-level events: each source event latched separately
	wire [3:0] ist_clr = wr_ist ? i_bus.wdata[3:0] : 4'h0;
	assign nxt_istat = (istat_ff & ~ist_clr) | i_src_evt;

	assign nxt_rdata = !i_bus.rd ? 32'h0 :
		sel_en  ? mac_irq_enable_ff :
		sel_st  ? status_word :
		sel_msk ? {28'h0, imask_ff} :
		sel_ist ? {28'h0, istat_ff} : 32'h0;

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			mac_irq_enable_ff <= `MRI_RST_ENABLE;
			status_ff         <= `MRI_RST_STATUS;
			imask_ff          <= `MRI_RST_MASK;
			istat_ff          <= `MRI_RST_ISTAT;
			rdata_ff          <= 32'h0;
			rx_irq_ff         <= 1'b0;
		end else begin
			mac_irq_enable_ff <= nxt_enable;
			status_ff         <= nxt_status;
			if (wr_msk) begin
				imask_ff <= i_bus.wdata[3:0];
			end
			istat_ff          <= nxt_istat;
			rdata_ff          <= nxt_rdata;
			rx_irq_ff         <= nxt_rx_irq;
		end
	end

	assign o_rdata   = rdata_ff;
	assign o_rx_irq  = rx_irq_ff;
	assign o_reg_irq = |(istat_ff & imask_ff);

	// assertions
	chk_irq_follows: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		o_rx_irq ==
		$past(rx_irq_master_en && |(status_ff & src_en)))
		else $error("rx irq does not follow gated flags");

	chk_master_blocks: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		!rx_irq_master_en ##1 !rx_irq_master_en
		|-> !o_rx_irq)
		else $error("rx irq with master off");

	chk_good_gate: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(rx_good_flag && rx_good_irq_en && rx_irq_master_en)
		|=> o_rx_irq)
		else $error("rx good did not raise irq");

	chk_good_mask: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(status_ff == 4'h8 && !rx_good_irq_en)
		|=> !o_rx_irq)
		else $error("masked rx good raised irq");

	chk_long_gate: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(too_long_flag && too_long_irq_en && rx_irq_master_en)
		|=> o_rx_irq)
		else $error("too long did not raise irq");

	chk_long_mask: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(status_ff == 4'h4 && !too_long_irq_en)
		|=> !o_rx_irq)
		else $error("masked too long raised irq");

	chk_ovf_gate: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(fifo_overflow_flag && fifo_overflow_irq_en && rx_irq_master_en)
		|=> o_rx_irq)
		else $error("overflow did not raise irq");

	chk_ovf_mask: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(status_ff == 4'h2 && !fifo_overflow_irq_en)
		|=> !o_rx_irq)
		else $error("masked overflow raised irq");

	chk_crc_gate: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(crc_fail_flag && crc_fail_irq_en && rx_irq_master_en)
		|=> o_rx_irq)
		else $error("crc fail did not raise irq");

	chk_crc_mask: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(status_ff == 4'h1 && !crc_fail_irq_en)
		|=> !o_rx_irq)
		else $error("masked crc raised irq");

	chk_rx_master: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(rx_irq_summary && rx_irq_master_en)
		|=> o_rx_irq)
		else $error("rx master did not pass irq");

	chk_master_off: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		!rx_irq_master_en
		|=> !o_rx_irq)
		else $error("irq passed with rx master off");

	chk_summary_idle: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		status_ff == 4'h0
		|-> !rx_irq_summary)
		else $error("summary high with no flag");

	chk_summary_noen: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		src_en == 4'h0
		|-> !rx_irq_summary)
		else $error("summary high with no enable");

	chk_summary_hit: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(status_ff & src_en) != 4'h0
		|-> rx_irq_summary)
		else $error("summary low with enabled flag");

	chk_irq_rise: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		$rose(o_rx_irq)
		|-> $past(rx_irq_master_en))
		else $error("irq rose without master");

	chk_irq_cause: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		$rose(o_rx_irq)
		|-> $past(rx_irq_summary))
		else $error("irq rose without summary");

	chk_summary_mask: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		!rx_irq_summary
		|=> !o_rx_irq)
		else $error("irq high with summary low");

	chk_clear_crc: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(wr_st && i_bus.wdata[1] && !i_src_evt[0])
		|=> !crc_fail_flag)
		else $error("crc flag not cleared");

	chk_clear_ovf: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(wr_st && i_bus.wdata[2] && !i_src_evt[1])
		|=> !fifo_overflow_flag)
		else $error("overflow flag not cleared");

	chk_clear_long: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(wr_st && i_bus.wdata[3] && !i_src_evt[2])
		|=> !too_long_flag)
		else $error("too long flag not cleared");

	chk_clear_good: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(wr_st && i_bus.wdata[4] && !i_src_evt[3])
		|=> !rx_good_flag)
		else $error("rx good flag not cleared");

	chk_set_crc: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		i_src_evt[0]
		|=> crc_fail_flag)
		else $error("crc event lost");

	chk_set_ovf: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		i_src_evt[1]
		|=> fifo_overflow_flag)
		else $error("overflow event lost");

	chk_set_long: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		i_src_evt[2]
		|=> too_long_flag)
		else $error("too long event lost");

	chk_set_wins: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		i_src_evt[3]
		|=> rx_good_flag)
		else $error("event lost against clear");

	chk_flag_hold: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(!wr_st && i_src_evt == 4'h0)
		|=> $stable(status_ff))
		else $error("status changed with no cause");

	chk_clear_irq: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(wr_st && i_src_evt == 4'h0
		&& (status_ff & ~i_bus.wdata[4:1]) == 4'h0)
		|=> ##1 !o_rx_irq)
		else $error("clear did not drop irq");

	chk_read_data: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(i_bus.rd && sel_en)
		|=> o_rdata == $past(mac_irq_enable_ff))
		else $error("enable readback wrong");

	chk_read_status: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(i_bus.rd && sel_st)
		|=> o_rdata == $past(status_word))
		else $error("status readback wrong");

	chk_read_idle: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		!i_bus.rd
		|=> o_rdata == 32'h0)
		else $error("read data without read");

	chk_read_mask: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(i_bus.rd && sel_msk)
		|=> o_rdata == {28'h0, $past(imask_ff)})
		else $error("mask readback wrong");

	chk_read_istat: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(i_bus.rd && sel_ist)
		|=> o_rdata == {28'h0, $past(istat_ff)})
		else $error("event status readback wrong");

	chk_enable_write: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		wr_en
		|=> mac_irq_enable_ff == $past(i_bus.wdata))
		else $error("enable write lost");

	chk_enable_hold: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		!wr_en
		|=> $stable(mac_irq_enable_ff))
		else $error("enable changed without write");

	chk_mask_write: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		wr_msk
		|=> imask_ff == $past(i_bus.wdata[3:0]))
		else $error("mask write lost");

	chk_mask_hold: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		!wr_msk
		|=> $stable(imask_ff))
		else $error("mask changed without write");

	chk_evt_latch: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		i_src_evt != 4'h0
		|=> (istat_ff & $past(i_src_evt)) == $past(i_src_evt))
		else $error("event status not latched");

	chk_evt_clear: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		(wr_ist && i_src_evt == 4'h0)
		|=> (istat_ff & $past(i_bus.wdata[3:0])) == 4'h0)
		else $error("event status not cleared");

	chk_reg_quiet: assert property (
		@(posedge i_mclk) disable iff (!i_nrst)
		imask_ff == 4'h0
		|-> !o_reg_irq)
		else $error("register irq with all masked");

endmodule : mri_top

// [core/mri_params.svh]
`ifndef MRI_PARAMS_SVH
`define MRI_PARAMS_SVH

// register word offsets (byte addresses)
`define MRI_OFF_ENABLE     4'h0
`define MRI_OFF_STATUS     4'h4
`define MRI_OFF_MASK       4'h8
`define MRI_OFF_ISTAT      4'hc

// enable and status bit positions
`define MRI_BIT_MASTER     0
`define MRI_BIT_CRC        1
`define MRI_BIT_OVF        2
`define MRI_BIT_LONG       3
`define MRI_BIT_GOOD       4
`define MRI_NSRC           4

// reset values
`define MRI_RST_ENABLE     32'h0000_0000
`define MRI_RST_STATUS     4'h0
`define MRI_RST_MASK       4'h0
`define MRI_RST_ISTAT      4'h0

`endif

// [core/mri_pkg.sv]
package mri_pkg;

	// one bit per receive source: bit0 crc, bit1 ovf, bit2 long, bit3 good
	typedef logic [3:0] mri_src_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} mri_bus_s;

endpackage : mri_pkg

// [dv/mri_cpu.sv]
`timescale 1ns/1ps
// cpu side: samples the level interrupt line once per cycle
module mri_cpu (
	input  wire logic i_mclk,
	input  wire logic i_irq,
	output logic      o_irq_seen
);
	always_ff @(posedge i_mclk) o_irq_seen <= i_irq;
endmodule : mri_cpu

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import mri_pkg::*;
	logic        i_mclk = 1'b0;
	logic        i_nrst = 1'b0;
	mri_bus_s    bus = '0;
	mri_src_t    evt = '0;
	logic [31:0] rdata;
	logic        rx_irq, reg_irq, seen;
	int          n_errors = 0, num_checks = 0;
	mri_top dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_bus(bus),
		.o_rdata(rdata), .i_src_evt(evt), .o_rx_irq(rx_irq),
		.o_reg_irq(reg_irq));
	mri_cpu cpu (.i_mclk(i_mclk), .i_irq(rx_irq), .o_irq_seen(seen));
	initial forever #5 i_mclk = ~i_mclk;
	task chk(string n, logic [31:0] e, logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task wr(logic [3:0] a, logic [31:0] d);
		@(posedge i_mclk); bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
		@(posedge i_mclk); bus.wr <= 1'b0;
	endtask : wr
	// read data live only in the cycle after the strobe
	task rd(logic [3:0] a, logic [31:0] e, string n);
		@(posedge i_mclk); bus.addr <= a; bus.rd <= 1'b1;
		@(posedge i_mclk); bus.rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask : rd
	task pulse(int i);
		@(posedge i_mclk); evt <= 4'h1 << i;
		@(posedge i_mclk); evt <= 4'h0;
	endtask : pulse
	task irq(logic e, logic r);
		repeat (2) @(posedge i_mclk);
		#1 chk("rx_irq", {31'h0, e}, {31'h0, rx_irq});
		chk("reg_irq", {31'h0, r}, {31'h0, reg_irq});
		chk("cpu_irq", {31'h0, e}, {31'h0, seen});
	endtask : irq
	task t_reset;
		rd(4'h0, 32'h0, "enable_rst");
		rd(4'h4, 32'h0, "status_rst");
		rd(4'h2, 32'h0, "unmapped");
	endtask : t_reset
	task t_src;
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, 32'h1); pulse(i); irq(1'b0, 1'b0);
			rd(4'h4, 32'h2 << i, "status");
			wr(4'h0, 32'h2 << i); irq(1'b0, 1'b0);
			wr(4'h0, (32'h2 << i) | 32'h1); irq(1'b1, 1'b0);
			rd(4'h4, (32'h2 << i) | 32'h1, "summary");
			wr(4'h4, 32'h2 << i); irq(1'b0, 1'b0);
			rd(4'hc, 32'h1 << i, "evt_status");
			wr(4'hc, 32'hf);
		end
	endtask : t_src
	// masked event status, then unmasked, then write-one clear
	task t_evt;
		pulse(2); wr(4'h0, 32'h0); irq(1'b0, 1'b0);
		wr(4'h8, 32'hf); irq(1'b0, 1'b1);
		rd(4'h8, 32'hf, "mask");
		wr(4'hc, 32'h4); irq(1'b0, 1'b0);
		rd(4'h4, 32'h8, "status_kept");
	endtask : t_evt
	task end_of_test;
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	initial begin
		#20000;
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge i_mclk);
		i_nrst <= 1'b1;
		t_reset();
		t_src();
		t_evt();
		end_of_test();
	end
endmodule : testbench
